// >>> lpms_pkg.sv
// Overview of operation
// R1 - active mode runs every function from the main oscillator
// R2 - light-sleep instruction in active mode enters standby
// R3 - standby: both oscillators run, cpu clocks stop, peripherals run, ports held
// R4 - standby ends on reset or interrupt request; reset resets everything
// R5 - interrupt wake from standby returns to active at next instruction
// R6 - after standby wake, service irq if enable set, else leave pending
// R7 - deep-sleep in active with watch select clear enters stop
// R8 - stop halts main oscillator; sub oscillator follows its disable bit
// R9 - other party holds reset or stop cancel one settle period
// R10 - stop cancel honoured only in stop, returns to active
// R11 - restart after stop keeps ram; cpu registers marked unsure
// R12 - stop resets cpu, timers, serial, a/d, lcd; outputs high impedance
// R13 - deep-sleep in active with watch select set enters watch
// R14 - watch: main osc off, sub on, only timer a, lcd and serial run
// R15 - lcd runs in watch only with a 32 kHz sub clock
// R16 - watch serial shifts on external clock but raises no interrupt
// R17 - standby and watch hold d ports; r ports hold or carry peripherals
// R18 - timer a or ext irq zero in watch enters subactive if low speed
// R19 - sleep in subactive enters watch unless direct transfer selected; code also enters watch while LOW_SPEED_ON_FLAG is set
// R20 - sleep in subactive with direct transfer goes straight to active; code does so only with LOW_SPEED_ON_FLAG clear
// R21 - sleep with irq enable clear and unmasked flag set is a no-op
// R22 - mode kept in a state register, gates decoded, reset forces active
package lpms_pkg;

  typedef enum logic [2:0] {
    LPMS_ACTIVE,
    LPMS_STANDBY,
    LPMS_STOP,
    LPMS_WATCH,
    LPMS_SUBACTIVE
  } lpms_mode_e;

  localparam int   LPMS_MODE_W   = 3;
  localparam int   LPMS_PIN_W    = 2;
  localparam int   LPMS_PIN_STOP_CANCEL_N = 0;
  localparam int   LPMS_PIN_EXT0 = 1;
  localparam logic LPMS_PIN_IDLE = 1'b1;
  localparam logic LPMS_RAME_RST = 1'b0;

endpackage : lpms_pkg

// >>> lpms_sync.sv
`timescale 1ns/1ps
module lpms_sync #(
  parameter int               WIDTH     = 2,
  parameter logic [WIDTH-1:0] RESET_VAL = '1
) (
  input  wire logic             SYS_CLK,
  input  wire logic             RST_N,
  input  wire logic [WIDTH-1:0] async_in,
  output logic      [WIDTH-1:0] sync_out
);

  typedef struct packed {
    logic [WIDTH-1:0] meta;
    logic [WIDTH-1:0] stable;
  } lpms_sync_s;

  lpms_sync_s st_ff;
  lpms_sync_s nxt_st;

  // first stage feeds only the second stage
  always_comb begin
    nxt_st.meta   = async_in;
    nxt_st.stable = st_ff.meta;
    if (!RST_N) begin
      nxt_st.meta   = RESET_VAL;
      nxt_st.stable = RESET_VAL;
    end
  end

  always_ff @(posedge SYS_CLK) begin
    st_ff <= nxt_st;
  end

  assign sync_out = st_ff.stable;

endmodule // lpms_sync

// >>> lpms_sequencer.sv
`timescale 1ns/1ps
module lpms_sequencer
  import lpms_pkg::*;
(
  input  wire logic                   SYS_CLK,
  input  wire logic                   RST_N,
  input  wire logic                   LIGHT_SLEEP_INSTR,
  input  wire logic                   DEEP_SLEEP_INSTR,
  input  wire logic                   TIMER_A_WATCH_SELECT,
  input  wire logic                   SUB_OSC_DISABLE_BIT,
  input  wire logic                   LOW_SPEED_ON_FLAG,
  input  wire logic                   DIRECT_TRANSFER_FLAG,
  input  wire logic                   GLOBAL_IRQ_ENABLE,
  input  wire logic                   IRQ_REQ,
  input  wire logic                   TIMER_A_IRQ,
  input  wire logic                   EXT_IRQ_ZERO_N,
  input  wire logic                   STOP_CANCEL_N,
  input  wire logic                   SUB_CLK_32K,
  input  wire logic                   R_PORT_PERIPH_SEL,
  output logic      [LPMS_MODE_W-1:0] MODE,
  output logic                        MAIN_OSC_EN,
  output logic                        SUB_OSC_EN,
  output logic                        CPU_CLK_EN,
  output logic                        CPU_RESET,
  output logic                        PERIPH_RESET,
  output logic                        TIMER_A_EN,
  output logic                        TIMER_BCD_EN,
  output logic                        SERIAL_EN,
  output logic                        SERIAL_IRQ_EN,
  output logic                        AD_EN,
  output logic                        LCD_EN,
  output logic                        D_PORT_HOLD,
  output logic                        R_PORT_HOLD,
  output logic                        IO_HIZ,
  output logic                        RESUME_NEXT,
  output logic                        IRQ_SERVICE,
  output logic                        SLEEP_NOP,
  output logic                        RESTART_ZERO,
  output logic                        RAM_ENABLE_FLAG,
  output logic                        REGS_UNSURE
);

  typedef struct packed {
    lpms_mode_e mode;
    logic       main_osc_en;
    logic       sub_osc_en;
    logic       cpu_clk_en;
    logic       cpu_reset;
    logic       periph_reset;
    logic       timer_a_en;
    logic       timer_bcd_en;
    logic       serial_en;
    logic       serial_irq_en;
    logic       ad_en;
    logic       lcd_en;
    logic       d_port_hold;
    logic       r_port_hold;
    logic       io_hiz;
    logic       resume_next;
    logic       irq_service;
    logic       sleep_nop;
    logic       restart_zero;
    logic       ram_enable;
    logic       regs_unsure;
    logic       ext_prev;
  } lpms_seq_state_s;

  lpms_seq_state_s st_ff;
  lpms_seq_state_s nxt_st;

  default clocking cb @(posedge SYS_CLK); endclocking
  default disable iff (!RST_N);

  logic [LPMS_PIN_W-1:0] pins_raw;
  logic [LPMS_PIN_W-1:0] pins_sync;
  logic                  stop_cancel_n_s;
  logic                  ext0_s;
  logic                  ext0_fall;
  logic                  any_sleep;
  logic                  sleep_blocked;

  assign pins_raw[LPMS_PIN_STOP_CANCEL_N] = STOP_CANCEL_N;
  assign pins_raw[LPMS_PIN_EXT0]  = EXT_IRQ_ZERO_N;

  lpms_sync #(
    .WIDTH     (LPMS_PIN_W),
    .RESET_VAL ({LPMS_PIN_W{LPMS_PIN_IDLE}})
  ) u_pin_sync (
    .SYS_CLK  (SYS_CLK),
    .RST_N    (RST_N),
    .async_in (pins_raw),
    .sync_out (pins_sync)
  );

  assign stop_cancel_n_s       = ~pins_sync[LPMS_PIN_STOP_CANCEL_N];
  assign ext0_s        = pins_sync[LPMS_PIN_EXT0];
  assign ext0_fall     = st_ff.ext_prev & ~ext0_s;
  assign any_sleep     = LIGHT_SLEEP_INSTR | DEEP_SLEEP_INSTR;
  assign sleep_blocked = any_sleep & ~GLOBAL_IRQ_ENABLE & IRQ_REQ; // R21

  always_comb begin
    nxt_st              = st_ff;
    nxt_st.resume_next  = 1'b0;
    nxt_st.irq_service  = 1'b0;
    nxt_st.sleep_nop    = 1'b0;
    nxt_st.restart_zero = 1'b0;
    nxt_st.ext_prev     = ext0_s;

    case (st_ff.mode)
      LPMS_ACTIVE: begin
        if (sleep_blocked) begin
          nxt_st.sleep_nop = 1'b1; // R21
        end else if (LIGHT_SLEEP_INSTR) begin
          nxt_st.mode = LPMS_STANDBY; // R2
        end else if (DEEP_SLEEP_INSTR) begin
          if (TIMER_A_WATCH_SELECT) begin
            nxt_st.mode = LPMS_WATCH; // R13
          end else begin
            nxt_st.mode = LPMS_STOP; // R7
          end
        end
      end
      LPMS_STANDBY: begin
        if (IRQ_REQ) begin
          nxt_st.mode        = LPMS_ACTIVE; // R4
          nxt_st.resume_next = 1'b1; // R5
          nxt_st.irq_service = GLOBAL_IRQ_ENABLE; // R6
        end
      end
      LPMS_STOP: begin
        // cancel input counts only here
        if (stop_cancel_n_s) begin
          nxt_st.mode         = LPMS_ACTIVE; // R10
          nxt_st.restart_zero = 1'b1;
          nxt_st.ram_enable   = 1'b1; // R11
          nxt_st.regs_unsure  = 1'b1; // R11
        end
      end
      LPMS_WATCH: begin
        if (TIMER_A_IRQ | ext0_fall) begin
          if (LOW_SPEED_ON_FLAG) begin
            nxt_st.mode = LPMS_SUBACTIVE; // R18
          end else begin
            nxt_st.mode = LPMS_ACTIVE;
          end
        end
      end
      LPMS_SUBACTIVE: begin
        if (sleep_blocked) begin
          nxt_st.sleep_nop = 1'b1; // R21
        end else if (any_sleep) begin
          if (!LOW_SPEED_ON_FLAG && DIRECT_TRANSFER_FLAG) begin
            nxt_st.mode = LPMS_ACTIVE; // R20
          end else begin
            nxt_st.mode = LPMS_WATCH; // R19
          end
        end
      end
      default: begin
        nxt_st.mode = LPMS_ACTIVE;
      end
    endcase

    if (!RST_N) begin
      nxt_st            = '0;
      nxt_st.mode       = LPMS_ACTIVE; // R22
      nxt_st.ram_enable = LPMS_RAME_RST; // R4
      nxt_st.ext_prev   = LPMS_PIN_IDLE;
    end

    // gates decoded from the mode being entered, so they track st_ff.mode
    nxt_st.main_osc_en   = 1'b0;
    nxt_st.sub_osc_en    = 1'b0;
    nxt_st.cpu_clk_en    = 1'b0;
    nxt_st.cpu_reset     = 1'b0;
    nxt_st.periph_reset  = 1'b0;
    nxt_st.timer_a_en    = 1'b0;
    nxt_st.timer_bcd_en  = 1'b0;
    nxt_st.serial_en     = 1'b0;
    nxt_st.serial_irq_en = 1'b0;
    nxt_st.ad_en         = 1'b0;
    nxt_st.lcd_en        = 1'b0;
    nxt_st.d_port_hold   = 1'b0;
    nxt_st.r_port_hold   = 1'b0;
    nxt_st.io_hiz        = 1'b0;
    case (nxt_st.mode)
      LPMS_ACTIVE: begin
        nxt_st.main_osc_en   = 1'b1; // R1
        nxt_st.sub_osc_en    = 1'b1;
        nxt_st.cpu_clk_en    = 1'b1;
        nxt_st.timer_a_en    = 1'b1;
        nxt_st.timer_bcd_en  = 1'b1;
        nxt_st.serial_en     = 1'b1;
        nxt_st.serial_irq_en = 1'b1;
        nxt_st.ad_en         = 1'b1;
        nxt_st.lcd_en        = 1'b1;
      end
      LPMS_STANDBY: begin
        nxt_st.main_osc_en   = 1'b1; // R3
        nxt_st.sub_osc_en    = 1'b1;
        nxt_st.timer_a_en    = 1'b1;
        nxt_st.timer_bcd_en  = 1'b1;
        nxt_st.serial_en     = 1'b1;
        nxt_st.serial_irq_en = 1'b1;
        nxt_st.ad_en         = 1'b1;
        nxt_st.lcd_en        = 1'b1;
        nxt_st.d_port_hold   = 1'b1; // R17
        nxt_st.r_port_hold   = ~R_PORT_PERIPH_SEL; // R17
      end
      LPMS_STOP: begin
        nxt_st.sub_osc_en    = ~SUB_OSC_DISABLE_BIT; // R8
        nxt_st.cpu_reset     = 1'b1; // R12
        nxt_st.periph_reset  = 1'b1; // R12
        nxt_st.io_hiz        = 1'b1; // R12
      end
      LPMS_WATCH: begin
        nxt_st.sub_osc_en    = 1'b1; // R14
        nxt_st.timer_a_en    = 1'b1; // R14
        nxt_st.serial_en     = 1'b1; // R16
        nxt_st.lcd_en        = SUB_CLK_32K; // R15
        nxt_st.d_port_hold   = 1'b1; // R17
        nxt_st.r_port_hold   = ~R_PORT_PERIPH_SEL; // R17
      end
      LPMS_SUBACTIVE: begin
        nxt_st.sub_osc_en    = 1'b1;
        nxt_st.cpu_clk_en    = 1'b1;
        nxt_st.timer_a_en    = 1'b1;
        nxt_st.timer_bcd_en  = 1'b1;
        nxt_st.serial_en     = 1'b1;
        nxt_st.serial_irq_en = 1'b1;
        nxt_st.lcd_en        = 1'b1;
      end
      default: begin
        nxt_st.main_osc_en   = 1'b1;
      end
    endcase
  end

  always_ff @(posedge SYS_CLK) begin
    st_ff <= nxt_st; // R22
  end

  assign MODE            = LPMS_MODE_W'(st_ff.mode);
  assign MAIN_OSC_EN     = st_ff.main_osc_en;
  assign SUB_OSC_EN      = st_ff.sub_osc_en;
  assign CPU_CLK_EN      = st_ff.cpu_clk_en;
  assign CPU_RESET       = st_ff.cpu_reset;
  assign PERIPH_RESET    = st_ff.periph_reset;
  assign TIMER_A_EN      = st_ff.timer_a_en;
  assign TIMER_BCD_EN    = st_ff.timer_bcd_en;
  assign SERIAL_EN       = st_ff.serial_en;
  assign SERIAL_IRQ_EN   = st_ff.serial_irq_en;
  assign AD_EN           = st_ff.ad_en;
  assign LCD_EN          = st_ff.lcd_en;
  assign D_PORT_HOLD     = st_ff.d_port_hold;
  assign R_PORT_HOLD     = st_ff.r_port_hold;
  assign IO_HIZ          = st_ff.io_hiz;
  assign RESUME_NEXT     = st_ff.resume_next;
  assign IRQ_SERVICE     = st_ff.irq_service;
  assign SLEEP_NOP       = st_ff.sleep_nop;
  assign RESTART_ZERO    = st_ff.restart_zero;
  assign RAM_ENABLE_FLAG = st_ff.ram_enable;
  assign REGS_UNSURE     = st_ff.regs_unsure;

  sequence seq_standby_wake;
    (st_ff.mode == LPMS_ACTIVE) && st_ff.resume_next;
  endsequence

  sequence seq_stop_cancel_n_restart;
    (st_ff.mode == LPMS_ACTIVE) && st_ff.restart_zero && st_ff.ram_enable
      && st_ff.regs_unsure ##1 !st_ff.restart_zero;
  endsequence

  AST_STANDBY_ENTRY: assert property ( // R2
    (st_ff.mode == LPMS_ACTIVE) && LIGHT_SLEEP_INSTR && !sleep_blocked
    |=> (st_ff.mode == LPMS_STANDBY) && !CPU_CLK_EN && MAIN_OSC_EN
  ) else $error("light sleep did not enter standby");

  AST_STOP_ENTRY: assert property ( // R7
    (st_ff.mode == LPMS_ACTIVE) && DEEP_SLEEP_INSTR && !LIGHT_SLEEP_INSTR
    && !sleep_blocked && !TIMER_A_WATCH_SELECT
    |=> (st_ff.mode == LPMS_STOP)
  ) else $error("deep sleep did not enter stop");

  AST_WATCH_ENTRY: assert property ( // R13
    (st_ff.mode == LPMS_ACTIVE) && DEEP_SLEEP_INSTR && !LIGHT_SLEEP_INSTR
    && !sleep_blocked && TIMER_A_WATCH_SELECT
    |=> (st_ff.mode == LPMS_WATCH)
  ) else $error("deep sleep did not enter watch");

  AST_STANDBY_WAKE: assert property ( // R5
    (st_ff.mode == LPMS_STANDBY) && IRQ_REQ
    |=> seq_standby_wake ##0 (IRQ_SERVICE == $past(GLOBAL_IRQ_ENABLE))
  ) else $error("standby wake or service decision wrong");

  AST_SLEEP_NOP: assert property ( // R21
    ((st_ff.mode == LPMS_ACTIVE) || (st_ff.mode == LPMS_SUBACTIVE))
    && any_sleep && !GLOBAL_IRQ_ENABLE && IRQ_REQ
    |=> SLEEP_NOP && $stable(st_ff.mode)
  ) else $error("blocked sleep changed mode");

  AST_STOP_GATES: assert property ( // R12
    (st_ff.mode == LPMS_STOP) |-> !MAIN_OSC_EN && CPU_RESET && PERIPH_RESET
    && IO_HIZ && !LCD_EN && !CPU_CLK_EN
  ) else $error("stop mode gates wrong");

  AST_STOP_CANCEL_N_WAKE: assert property ( // R10
    (st_ff.mode == LPMS_STOP) && stop_cancel_n_s |=> seq_stop_cancel_n_restart
  ) else $error("stop cancel did not restart");

  AST_STOP_CANCEL_N_IGNORED: assert property ( // R10
    (st_ff.mode == LPMS_WATCH) && stop_cancel_n_s && !TIMER_A_IRQ && !ext0_fall
    |=> (st_ff.mode == LPMS_WATCH) && !RESTART_ZERO
  ) else $error("stop cancel acted outside stop");

  AST_WATCH_TO_SUB: assert property ( // R18
    (st_ff.mode == LPMS_WATCH) && (TIMER_A_IRQ || ext0_fall)
    |=> (st_ff.mode == ($past(LOW_SPEED_ON_FLAG) ? LPMS_SUBACTIVE
                                                  : LPMS_ACTIVE))
  ) else $error("watch wake went to wrong mode");

  AST_SUB_SLEEP: assert property ( // R20
    (st_ff.mode == LPMS_SUBACTIVE) && any_sleep && !sleep_blocked
    |=> (st_ff.mode == (($past(DIRECT_TRANSFER_FLAG)
                         && !$past(LOW_SPEED_ON_FLAG)) ? LPMS_ACTIVE
                                                       : LPMS_WATCH))
  ) else $error("subactive sleep went to wrong mode");

  AST_WATCH_GATES: assert property ( // R14
    (st_ff.mode == LPMS_WATCH) |-> !MAIN_OSC_EN && SUB_OSC_EN && TIMER_A_EN
    && !TIMER_BCD_EN && !AD_EN && !CPU_CLK_EN && !SERIAL_IRQ_EN
    && D_PORT_HOLD
  ) else $error("watch mode gates wrong");

  AST_RESET_ACTIVE: assert property ( // R22
    disable iff (1'b0)
    !RST_N |=> (st_ff.mode == LPMS_ACTIVE) && MAIN_OSC_EN && CPU_CLK_EN
    && !RAM_ENABLE_FLAG && !REGS_UNSURE
  ) else $error("reset did not force active mode");

endmodule // lpms_sequencer

// >>> lpms_pin_model.sv
`timescale 1ns/1ps
module lpms_pin_model #(
  parameter int SETTLE = 4
) (
  input  wire logic clk,
  input  wire logic cancel_req,
  input  wire logic ext_req,
  output logic      stop_cancel_n,
  output logic      ext_irq_zero_n
);
  initial begin
    stop_cancel_n  = 1'b1;
    ext_irq_zero_n = 1'b1;
  end
  // cancel held low until the oscillator has settled
  always @(posedge cancel_req) begin
    @(negedge clk) stop_cancel_n = 1'b0;
    repeat (SETTLE) @(negedge clk);
    stop_cancel_n = 1'b1;
  end
  // low long enough to count as a falling edge
  always @(posedge ext_req) begin
    @(negedge clk) ext_irq_zero_n = 1'b0;
    repeat (SETTLE) @(negedge clk);
    ext_irq_zero_n = 1'b1;
  end
endmodule // lpms_pin_model

// >>> lpms_sequencer_tb.sv
`timescale 1ns/1ps
module lpms_sequencer_tb
  import lpms_pkg::*;
;
  logic        clk, rst_n, li, de, tma, ssr, low_speed_on_flag, direct_transfer_flag, ie, irq, tai;
  logic        s32, sel, can_rq, ext_rq, scn, exn;
  logic        resume, svc, nop, rz, ram, unsure;
  logic [2:0]  mode;
  wire  [13:0] g;
  int          err_total, check_count, seed;

  lpms_pin_model i_lpms_pin_model (
    .clk(clk), .cancel_req(can_rq), .ext_req(ext_rq),
    .stop_cancel_n(scn), .ext_irq_zero_n(exn));

  lpms_sequencer i_lpms_sequencer (
    .SYS_CLK(clk), .RST_N(rst_n),
    .LIGHT_SLEEP_INSTR(li), .DEEP_SLEEP_INSTR(de),
    .TIMER_A_WATCH_SELECT(tma), .SUB_OSC_DISABLE_BIT(ssr),
    .LOW_SPEED_ON_FLAG(low_speed_on_flag), .DIRECT_TRANSFER_FLAG(direct_transfer_flag),
    .GLOBAL_IRQ_ENABLE(ie), .IRQ_REQ(irq), .TIMER_A_IRQ(tai),
    .EXT_IRQ_ZERO_N(exn), .STOP_CANCEL_N(scn), .SUB_CLK_32K(s32),
    .R_PORT_PERIPH_SEL(sel), .MODE(mode),
    .MAIN_OSC_EN(g[13]), .SUB_OSC_EN(g[12]), .CPU_CLK_EN(g[11]),
    .CPU_RESET(g[10]), .PERIPH_RESET(g[9]), .TIMER_A_EN(g[8]),
    .TIMER_BCD_EN(g[7]), .SERIAL_EN(g[6]), .SERIAL_IRQ_EN(g[5]),
    .AD_EN(g[4]), .LCD_EN(g[3]), .D_PORT_HOLD(g[2]),
    .R_PORT_HOLD(g[1]), .IO_HIZ(g[0]), .RESUME_NEXT(resume),
    .IRQ_SERVICE(svc), .SLEEP_NOP(nop), .RESTART_ZERO(rz),
    .RAM_ENABLE_FLAG(ram), .REGS_UNSURE(unsure));

  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end

  // gate pattern expected for each mode
  function automatic logic [13:0] gx(input lpms_mode_e m);
    case (m)
      LPMS_ACTIVE:  gx = {3'b111, 2'b00, 6'h3F, 3'b000};
      LPMS_STANDBY: gx = {3'b110, 2'b00, 6'h3F, 1'b1, ~sel, 1'b0};
      LPMS_STOP:    gx = {1'b0, ~ssr, 3'b011, 6'h00, 3'b001};
      LPMS_WATCH:   gx = {5'b01000, 5'b10100, s32, 1'b1, ~sel, 1'b0};
      default:      gx = {5'b01100, 6'b111101, 3'b000};
    endcase
  endfunction

  task automatic wrap_up;
    $display("checks %0d mismatches %0d", check_count, err_total);
    if (err_total == 0 && check_count > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  task automatic chk(input string nm, input logic [15:0] e,
                     input logic [15:0] s);
    check_count++;
    if (s !== e) begin
      err_total++;
      $display("mismatch %0s expected %0h seen %0h", nm, e, s);
    end
  endtask

  task automatic ckm(input lpms_mode_e m);
    chk("mode", 16'(m), 16'(mode));
    chk("gates", 16'(gx(m)), 16'(g));
  endtask

  task automatic ins(input logic l, input logic d);
    @(negedge clk);
    li = l;
    de = d;
    @(negedge clk);
    li = 1'b0;
    de = 1'b0;
  endtask

  task automatic tpulse;
    tai = 1'b1;
    @(negedge clk);
    tai = 1'b0;
  endtask

  task automatic wt(input lpms_mode_e m);
    int n;
    n = 0;
    while (mode !== m && n < 12) begin
      @(negedge clk);
      n++;
    end
  endtask

  initial begin
    #(8 * 20000);
    err_total++;
    wrap_up();
  end

  initial begin
    {li, de, tma, ssr, low_speed_on_flag, direct_transfer_flag, ie, irq, tai} = '0;
    {s32, sel, can_rq, ext_rq} = '0;
    seed = 32'hBC7BA5D4;
    rst_n = 1'b0;
    repeat (10) @(negedge clk);
    rst_n = 1'b1;
    @(negedge clk);
    ckm(LPMS_ACTIVE);
    for (int k = 0; k < 4; k++) begin
      {sel, ssr, s32, ie} = 4'($random(seed));
      ins(1'b1, 1'b0);
      ckm(LPMS_STANDBY);
      ins(1'b0, 1'b1);
      ckm(LPMS_STANDBY);
      irq = 1'b1;
      wt(LPMS_ACTIVE);
      irq = 1'b0;
      ckm(LPMS_ACTIVE);
      chk("resume", 1'b1, resume);
      chk("service", ie, svc);
      tma = 1'b0;
      ins(0, 1);
      ckm(LPMS_STOP);
      ins(1, 0);
      ckm(LPMS_STOP);
      can_rq = 1'b1;
      wt(LPMS_ACTIVE);
      can_rq = 1'b0;
      ckm(LPMS_ACTIVE);
      chk("restart", 1'b1, rz);
      chk("ram", 1'b1, ram);
      chk("unsure", 1'b1, unsure);
      tma = 1'b1;
      ins(0, 1);
      ckm(LPMS_WATCH);
      low_speed_on_flag = 1'b1;
      tpulse();
      ckm(LPMS_SUBACTIVE);
      low_speed_on_flag = 1'b0;
      direct_transfer_flag = 1'b1;
      ins(1, 0);
      ckm(LPMS_ACTIVE);
      direct_transfer_flag = 1'b0;
      ins(0, 1);
      low_speed_on_flag = 1'b1;
      ext_rq = 1'b1;
      wt(LPMS_SUBACTIVE);
      ext_rq = 1'b0;
      ckm(LPMS_SUBACTIVE);
      ins(1, 0);
      ckm(LPMS_WATCH);
      tpulse();
      low_speed_on_flag = 1'b0;
      ins(0, 1);
      ckm(LPMS_WATCH);
      tpulse();
      ckm(LPMS_ACTIVE);
      $display("test %0d end", k);
    end
    ie = 1'b0;
    ins(1, 0);
    irq = 1'b1;
    wt(LPMS_ACTIVE);
    chk("service", 1'b0, svc);
    ins(1, 0);
    chk("nop", 1'b1, nop);
    ckm(LPMS_ACTIVE);
    irq = 1'b0;
    tma = 1'b1;
    ins(0, 1);
    ckm(LPMS_WATCH);
    can_rq = 1'b1;
    repeat (8) begin
      @(negedge clk);
      chk("restart", 1'b0, rz);
      chk("mode", 16'(LPMS_WATCH), 16'(mode));
    end
    can_rq = 1'b0;
    tpulse();
    ckm(LPMS_ACTIVE);
    $display("test corner end");
    tma = 1'b0;
    ins(0, 1);
    ckm(LPMS_STOP);
    rst_n = 1'b0;
    repeat (3) @(negedge clk);
    rst_n = 1'b1;
    ckm(LPMS_ACTIVE);
    chk("ram", 1'b0, ram);
    chk("unsure", 1'b0, unsure);
    $display("test reset end");
    wrap_up();
  end
endmodule // lpms_sequencer_tb
